/* File: src/psr_consts.vh */
`ifndef PSR_CONSTS_VH
`define PSR_CONSTS_VH

// Register indices on the request port.
`define PSR_IDX_TEMP 4'h0
`define PSR_IDX_CHANNEL1_COMPENSATED_FIELD 4'h1
`define PSR_IDX_CHANNEL2_COMPENSATED_FIELD 4'h2
`define PSR_IDX_CH1_CORR 4'h3
`define PSR_IDX_CH2_CORR 4'h4
`define PSR_IDX_POSITION 4'h5
`define PSR_IDX_OUTVAL 4'h6
`define PSR_IDX_AMPLITUDE 4'h7
`define PSR_IDX_FAULT 4'h8
`define PSR_IDX_PROG_FAULT 4'h9
`define PSR_IDX_MAKER1 4'ha
`define PSR_IDX_MAKER2 4'hb
`define PSR_IDX_USER1 4'hc
`define PSR_IDX_USER2 4'hd
`define PSR_IDX_LOCK 4'he

// Fault word field positions.
`define PSR_FB_VREG_LOW 12
`define PSR_FB_ADC_STUCK 11
`define PSR_FB_CLAMP_HI 9
`define PSR_FB_CLAMP_LO 8
`define PSR_FB_CH1_CLIP 7
`define PSR_FB_CH2_CLIP 6
`define PSR_FB_DSP 5
`define PSR_FB_NVM 4
`define PSR_FB_ROM 3
`define PSR_FB_TEMP 2
`define PSR_FB_MAG_HI 1
`define PSR_FB_MAG_LO 0

// Programming fault word field positions.
`define PSR_PB_PUMP 10
`define PSR_PB_SUPPLY 9

// Reset values and code limits.
`define PSR_RST_WORD 16'h0000
`define PSR_CODE_MAX 16'h7fff

// Amplitude scale of 1.6, as 205/128.
`define PSR_AMP_MUL 8'hcd
`define PSR_AMP_SHIFT 7

// Nonvolatile cell programming time.
`define PSR_CLK_MHZ 25
`define PSR_PROG_TIME_US 8
`define PSR_PROG_CYCLES (`PSR_PROG_TIME_US * `PSR_CLK_MHZ)

`endif

/* File: src/psr_amplitude.v */
`timescale 1ns/1ns
`include "psr_consts.vh"

module psr_amplitude (
  // Clock and reset.
  input wire clk_i,
  input wire rst_i,
  // Operands.
  input wire start_i,
  input wire scale_i,
  input wire signed [15:0] a_i,
  input wire signed [15:0] b_i,
  // Result.
  output reg done_o,
  output reg [15:0] amp_o
);

  reg [31:0] rem_q;
  reg [31:0] root_q;
  reg [31:0] bit_q;
  reg busy_q;
  reg scale_q;
  wire [31:0] sq_a;
  wire [31:0] sq_b;
  wire [31:0] trial;
  wire [31:0] nxt;
  wire [24:0] scaled;
  wire [16:0] res;

  // Squares of the magnitudes, sum fits 32 bits.
  // Operands are sign-extended first so the product keeps all 32 bits.
  assign sq_a = {{16{a_i[15]}}, a_i} * {{16{a_i[15]}}, a_i};
  assign sq_b = {{16{b_i[15]}}, b_i} * {{16{b_i[15]}}, b_i};
  // The partial root needs the full width while the trial bit is high.
  assign trial = root_q + bit_q;
  // Next root value is taken before the final shift so it is ready on done.
  assign nxt = (rem_q >= trial) ? (root_q >> 1) + bit_q : (root_q >> 1);
  // After the last step the root fits 17 bits.
  assign res = nxt[16:0];
  assign scaled = res * `PSR_AMP_MUL;

  // Bitwise square root, one result bit each cycle.
  always @(posedge clk_i) begin
    if (rst_i) begin
      rem_q <= 32'h00000000;
      root_q <= 32'h00000000;
      bit_q <= 32'h00000000;
      busy_q <= 1'b0;
      scale_q <= 1'b0;
      done_o <= 1'b0;
      amp_o <= `PSR_RST_WORD;
    end else begin
      done_o <= 1'b0;
      if (!busy_q && start_i) begin
        rem_q <= sq_a + sq_b;
        root_q <= 32'h00000000;
        bit_q <= 32'h40000000;
        busy_q <= 1'b1;
        scale_q <= scale_i;
      end else if (busy_q) begin
        if (rem_q >= trial) begin
          rem_q <= rem_q - trial;
          root_q <= (root_q >> 1) + bit_q;
        end else begin
          root_q <= root_q >> 1;
        end
        bit_q <= bit_q >> 2;
        if (bit_q == 32'h00000001) begin
          busy_q <= 1'b0;
          done_o <= 1'b1;
          // With both offset selects off, the root is scaled by 1.6.
          if (scale_q) begin // R7
            amp_o <= (scaled[24:`PSR_AMP_SHIFT] > 18'h0ffff) ? 16'hffff :
                     scaled[22:`PSR_AMP_SHIFT];
          end else begin
            amp_o <= res[16] ? 16'hffff : res[15:0];
          end
        end
      end
    end
  end

endmodule // psr_amplitude

/* File: src/psr_faults.v */
`timescale 1ns/1ns
`include "psr_consts.vh"

module psr_faults (
  // Clock and reset.
  input wire clk_i,
  input wire rst_i,
  // Monitor levels.
  input wire vreg_low_i,
  input wire adc_stuck_i,
  input wire ch1_clip_i,
  input wire ch2_clip_i,
  input wire dsp_fail_i,
  input wire nvm_fail_i,
  input wire [16:0] rom_word_i,
  input wire rom_valid_i,
  input wire temp_valid_i,
  // Values checked here.
  input wire [15:0] outval_i,
  input wire [15:0] clamp_hi_i,
  input wire [15:0] clamp_lo_i,
  input wire [15:0] amp_i,
  input wire signed [15:0] mag_hi_i,
  input wire signed [15:0] mag_lo_i,
  // Assembled fault word.
  output reg [15:0] fault_o
);

  reg rom_err_q;
  reg [15:0] w;
  wire signed [16:0] amp_s;

  assign amp_s = {1'b0, amp_i};

  // ROM parity is checked word by word and the last verdict is held.
  always @(posedge clk_i) begin
    if (rst_i) begin
      rom_err_q <= 1'b0;
    end else if (rom_valid_i) begin
      rom_err_q <= ^rom_word_i; // R12
    end
  end

  // Fault word; unused bits stay zero.
  always @* begin
    w = `PSR_RST_WORD; // R8
    w[`PSR_FB_VREG_LOW] = vreg_low_i; // R9
    w[`PSR_FB_ADC_STUCK] = adc_stuck_i; // R9
    w[`PSR_FB_CLAMP_HI] = (outval_i >= clamp_hi_i); // R10
    w[`PSR_FB_CLAMP_LO] = (outval_i <= clamp_lo_i); // R10
    w[`PSR_FB_CH1_CLIP] = ch1_clip_i; // R11
    w[`PSR_FB_CH2_CLIP] = ch2_clip_i; // R11
    w[`PSR_FB_DSP] = dsp_fail_i; // R12
    w[`PSR_FB_NVM] = nvm_fail_i; // R12
    w[`PSR_FB_ROM] = rom_err_q; // R12
    w[`PSR_FB_TEMP] = !temp_valid_i; // R13
    w[`PSR_FB_MAG_HI] = (amp_s > mag_hi_i); // R14
    w[`PSR_FB_MAG_LO] = (amp_s < mag_lo_i); // R14
  end

  // Registered so that a read sees one coherent snapshot.
  always @(posedge clk_i) begin
    if (rst_i) begin
      fault_o <= `PSR_RST_WORD;
    end else begin
      fault_o <= w; // R8
    end
  end

endmodule // psr_faults

/* File: src/psr_readout.v */
`timescale 1ns/1ns
`include "psr_consts.vh"

// Behaviour
// R1 - Temperature held 16 bits, codes to 32767
// R2 - Typical temperature codes 100 and 12000
// R3 - Two compensated channel fields, signed 16-bit
// R4 - Corrected channel fields feed angle computation
// R5 - Position unsigned, codes 0 to 32767
// R6 - Output value unsigned, codes 0 to 32767
// R7 - Amplitude 1.6 times root when selects zero
// R8 - Fault word, bits 15:13 and 10 zero
// R9 - Bit 12 low regulator, bit 11 stuck converter
// R10 - Bits 9 and 8 flag clamping levels
// R11 - Bits 7 and 6 flag channel clipping
// R12 - Bits 5,4,3 flag processor, memory, ROM
// R13 - Bit 2 flags invalid temperature reading
// R14 - Bits 1 and 0 flag field limits
// R15 - Programming faults bits 10 and 9 only
// R16 - Programmer checks both acknowledges
// R17 - Programmer reads programming faults on miss
// R18 - Programmer sets lock after final programming
// R19 - Reads still answered after locking
// R20 - Two read-only maker production words
// R21 - Two writable nonvolatile user words
// R22 - Measurements volatile, configuration nonvolatile
// R23 - Offset selects decide which channel offset
// R24 - Writes to measurement registers are ignored
module psr_readout #(
  parameter [15:0] MAKER_INFO_1 = 16'h1234, // Arbitrary value.
  parameter [15:0] MAKER_INFO_2 = 16'h5678, // Arbitrary value.
  parameter PROG_CYCLES = `PSR_PROG_CYCLES
) (
  // Clock and reset.
  input wire clk_i,
  input wire rst_i,
  // Register request port.
  input wire req_i,
  input wire req_write_i,
  input wire [3:0] req_addr_i,
  input wire [15:0] req_wdata_i,
  // Register answer port.
  output reg rsp_valid_o,
  output reg [15:0] rsp_rdata_o,
  output reg ack1_o,
  output reg ack2_o,
  output reg busy_o,
  // Signal processor results.
  input wire sample_i,
  input wire [15:0] temp_raw_i,
  input wire signed [15:0] channel1_compensated_field_i,
  input wire signed [15:0] channel2_compensated_field_i,
  input wire signed [15:0] ch1_gain_corr_i,
  input wire signed [15:0] ch2_gain_corr_i,
  input wire [15:0] position_raw_i,
  input wire [15:0] outval_raw_i,
  // Configuration values.
  input wire signed [15:0] cust_offset_i,
  input wire signed [15:0] offset_select_channel1_i,
  input wire signed [15:0] offset_select_channel2_i,
  input wire [15:0] clamp_hi_i,
  input wire [15:0] clamp_lo_i,
  input wire signed [15:0] mag_hi_i,
  input wire signed [15:0] mag_lo_i,
  // Monitor levels.
  input wire vreg_low_i,
  input wire adc_stuck_i,
  input wire ch1_clip_i,
  input wire ch2_clip_i,
  input wire dsp_fail_i,
  input wire nvm_fail_i,
  input wire [16:0] rom_word_i,
  input wire rom_valid_i,
  input wire temp_valid_i,
  input wire pump_low_i,
  input wire prog_supply_low_i,
  // Status.
  output reg locked_o
);

  // Programming states: waiting, timed cell write, commit or discard.
  localparam ST_IDLE = 2'b00;
  localparam ST_PROG = 2'b01;
  localparam ST_END = 2'b10;

  // Measurement registers, volatile.
  reg [15:0] junction_temperature_q;
  reg [15:0] channel1_compensated_field_q;
  reg [15:0] channel2_compensated_field_q;
  reg [15:0] channel1_corrected_field_q;
  reg [15:0] channel2_corrected_field_q;
  reg [15:0] computed_position_q;
  reg [15:0] output_value_q;
  reg [15:0] programming_fault_flags_q;
  // Nonvolatile user words and lock.
  reg [15:0] user_info_q [0:1];
  reg lock_q;
  // Programming sequence.
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [15:0] cnt_q;
  reg tgt_lock_q;
  reg tgt_sel_q;
  reg [15:0] tgt_data_q;
  reg amp_start_q;
  // Read path.
  reg [15:0] rd_mux;
  wire [15:0] field_amplitude;
  wire [15:0] fault_flags;
  wire prog_start;
  wire signed [15:0] corr1;
  wire signed [15:0] corr2;
  wire sel_off;
  wire id_write;
  wire lock_write;
  wire accept;

  // Limit an unsigned code to the 15-bit range.
  // Codes above 32767 are never shown in the temperature, position and output value words.
  function [15:0] clip15;
    input [15:0] v;
    begin
      clip15 = (v > `PSR_CODE_MAX) ? `PSR_CODE_MAX : v;
    end
  endfunction

  // Saturating signed add of an optional offset.
  function [15:0] add_sat;
    input [15:0] a;
    input [15:0] b;
    input en;
    reg [16:0] s;
    begin
      s = {a[15], a} + (en ? {b[15], b} : 17'h00000);
      if (s[16] != s[15]) begin
        add_sat = s[16] ? 16'h8000 : 16'h7fff;
      end else begin
        add_sat = s[15:0];
      end
    end
  endfunction

  // True for the two writable user word indices.
  function is_user;
    input [3:0] idx;
    begin
      is_user = (idx == `PSR_IDX_USER1) || (idx == `PSR_IDX_USER2);
    end
  endfunction

  // Offset joins a channel only where its select is nonzero.
  assign corr1 = add_sat(ch1_gain_corr_i, cust_offset_i,
                         offset_select_channel1_i != 16'h0000); // R23
  assign corr2 = add_sat(ch2_gain_corr_i, cust_offset_i,
                         offset_select_channel2_i != 16'h0000); // R23
  assign sel_off = (offset_select_channel1_i == 16'h0000) &&
                   (offset_select_channel2_i == 16'h0000); // R7

  // Request classification; programming blocks new requests.
  // A request that meets busy_o high is dropped without any answer, so
  // the programmer has to wait for busy_o to fall before the next one.
  // Once locked, user and lock writes fall back to a plain answer.
  assign accept = req_i && !busy_o;
  assign id_write = accept && req_write_i && !lock_q &&
                    is_user(req_addr_i); // R21
  assign lock_write = accept && req_write_i && !lock_q &&
                      (req_addr_i == `PSR_IDX_LOCK) && req_wdata_i[0];
  assign prog_start = id_write || lock_write;

  // Measurement capture on each processor result; bus writes never land.
  // The amplitude engine starts one cycle later from these registers, so
  // its result matches the fields that a read returns only after its 16 root steps finish.
  always @(posedge clk_i) begin
    if (rst_i) begin
      junction_temperature_q <= `PSR_RST_WORD;
      channel1_compensated_field_q <= `PSR_RST_WORD;
      channel2_compensated_field_q <= `PSR_RST_WORD;
      channel1_corrected_field_q <= `PSR_RST_WORD;
      channel2_corrected_field_q <= `PSR_RST_WORD;
      computed_position_q <= `PSR_RST_WORD;
      output_value_q <= `PSR_RST_WORD;
      amp_start_q <= 1'b0;
    end else begin
      amp_start_q <= sample_i;
      if (sample_i) begin // R22 R24
        junction_temperature_q <= clip15(temp_raw_i); // R1 R2
        channel1_compensated_field_q <= channel1_compensated_field_i; // R3
        channel2_compensated_field_q <= channel2_compensated_field_i; // R3
        channel1_corrected_field_q <= corr1; // R4
        channel2_corrected_field_q <= corr2; // R4
        computed_position_q <= clip15(position_raw_i); // R5
        output_value_q <= clip15(outval_raw_i); // R6
      end
    end
  end

  // Amplitude from the captured corrected fields.
  // Its done pulse is not needed: reads simply see the last result.
  psr_amplitude u_amp (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(amp_start_q),
    .scale_i(sel_off),
    .a_i(channel1_corrected_field_q),
    .b_i(channel2_corrected_field_q),
    .done_o(),
    .amp_o(field_amplitude)
  );

  // Fault word assembly.
  psr_faults u_faults (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .vreg_low_i(vreg_low_i),
    .adc_stuck_i(adc_stuck_i),
    .ch1_clip_i(ch1_clip_i),
    .ch2_clip_i(ch2_clip_i),
    .dsp_fail_i(dsp_fail_i),
    .nvm_fail_i(nvm_fail_i),
    .rom_word_i(rom_word_i),
    .rom_valid_i(rom_valid_i),
    .temp_valid_i(temp_valid_i),
    .outval_i(output_value_q),
    .clamp_hi_i(clamp_hi_i),
    .clamp_lo_i(clamp_lo_i),
    .amp_i(field_amplitude),
    .mag_hi_i(mag_hi_i),
    .mag_lo_i(mag_lo_i),
    .fault_o(fault_flags)
  );

  // Read selection; lock has no effect on reads.
  // Amplitude and fault word come straight from their own registers.
  always @* begin
    case (req_addr_i) // R19
      `PSR_IDX_TEMP: rd_mux = junction_temperature_q;
      `PSR_IDX_CHANNEL1_COMPENSATED_FIELD: rd_mux = channel1_compensated_field_q;
      `PSR_IDX_CHANNEL2_COMPENSATED_FIELD: rd_mux = channel2_compensated_field_q;
      `PSR_IDX_CH1_CORR: rd_mux = channel1_corrected_field_q;
      `PSR_IDX_CH2_CORR: rd_mux = channel2_corrected_field_q;
      `PSR_IDX_POSITION: rd_mux = computed_position_q;
      `PSR_IDX_OUTVAL: rd_mux = output_value_q;
      `PSR_IDX_AMPLITUDE: rd_mux = field_amplitude;
      `PSR_IDX_FAULT: rd_mux = fault_flags;
      `PSR_IDX_PROG_FAULT: rd_mux = programming_fault_flags_q;
      `PSR_IDX_MAKER1: rd_mux = MAKER_INFO_1; // R20
      `PSR_IDX_MAKER2: rd_mux = MAKER_INFO_2; // R20
      `PSR_IDX_USER1: rd_mux = user_info_q[0];
      `PSR_IDX_USER2: rd_mux = user_info_q[1];
      `PSR_IDX_LOCK: rd_mux = {15'h0000, lock_q};
      default: rd_mux = `PSR_RST_WORD;
    endcase
  end

  // Every accepted request is answered one cycle later.
  // Read data changes only on reads, so a write answer keeps the last
  // word read on the data output.
  always @(posedge clk_i) begin
    if (rst_i) begin
      rsp_valid_o <= 1'b0;
      rsp_rdata_o <= `PSR_RST_WORD;
      ack1_o <= 1'b0;
    end else begin
      rsp_valid_o <= accept;
      ack1_o <= prog_start; // R16
      if (accept && !req_write_i) begin
        rsp_rdata_o <= rd_mux; // R19
      end
    end
  end

  // Programming sequence state.
  always @* begin
    case (state_q)
      ST_IDLE: state_d = prog_start ? ST_PROG : ST_IDLE;
      ST_PROG: state_d = (cnt_q == 16'h0000) ? ST_END : ST_PROG;
      ST_END: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  // Timed programming of a nonvolatile word with fault capture.
  // The word is committed only at the end, so a supply dip anywhere in
  // the write window leaves the old contents in place.
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      cnt_q <= 16'h0000;
      tgt_lock_q <= 1'b0;
      tgt_sel_q <= 1'b0;
      tgt_data_q <= `PSR_RST_WORD;
      programming_fault_flags_q <= `PSR_RST_WORD;
      user_info_q[0] <= `PSR_RST_WORD;
      user_info_q[1] <= `PSR_RST_WORD;
      lock_q <= 1'b0;
      ack2_o <= 1'b0;
      busy_o <= 1'b0;
      locked_o <= 1'b0;
    end else begin
      state_q <= state_d;
      ack2_o <= 1'b0;
      locked_o <= lock_q;
      // Busy falls together with the second acknowledge.
      busy_o <= (state_d != ST_IDLE);
      case (state_q)
        ST_IDLE: begin
          if (prog_start) begin
            cnt_q <= PROG_CYCLES[15:0] - 16'h0001;
            tgt_lock_q <= lock_write;
            tgt_sel_q <= (req_addr_i == `PSR_IDX_USER2);
            tgt_data_q <= req_wdata_i;
            // A new operation starts with a clean fault word.
            programming_fault_flags_q <= `PSR_RST_WORD; // R15
          end
        end
        ST_PROG: begin
          cnt_q <= cnt_q - 16'h0001;
          // Faults stick for the rest of the operation.
          if (pump_low_i) begin
            programming_fault_flags_q[`PSR_PB_PUMP] <= 1'b1; // R15
          end
          if (prog_supply_low_i) begin
            programming_fault_flags_q[`PSR_PB_SUPPLY] <= 1'b1; // R15
          end
        end
        ST_END: begin
          // Failed cells are not committed and give no second ack.
          // The fault word stays readable until the next operation.
          if (programming_fault_flags_q == `PSR_RST_WORD) begin
            ack2_o <= 1'b1; // R16 R17
            if (tgt_lock_q) begin
              lock_q <= 1'b1; // R18
            end else begin
              user_info_q[tgt_sel_q] <= tgt_data_q; // R21
            end
          end
        end
        default: begin
          cnt_q <= 16'h0000;
        end
      endcase
    end
  end

endmodule // psr_readout

/* File: bench/psr_readout_sva.sv */
`timescale 1ns/1ns
`include "psr_consts.vh"
module psr_chk #(
  parameter [15:0] MAKER_INFO_1 = 16'h1234,
  parameter int PROG_CYCLES = 4
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Request side.
  input wire logic req_i,
  input wire logic req_write_i,
  input wire logic [3:0] req_addr_i,
  // Answer side.
  input wire logic rsp_valid_o,
  input wire logic [15:0] rsp_rdata_o,
  input wire logic ack1_o,
  input wire logic ack2_o,
  input wire logic busy_o,
  input wire logic locked_o
);
  // A request counts only while no programming runs.
  wire take = req_i && !busy_o;
  wire rd = take && !req_write_i;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Answers follow taken requests only.
  property p_rsp; take |=> rsp_valid_o; endproperty
  a_rsp: assert property (p_rsp) else $error("request unanswered");
  property p_idle; !take |=> !rsp_valid_o && !ack1_o; endproperty
  a_idle: assert property (p_idle) else $error("answer without take");
  // Fixed zero fields and code limits of read words.
  property p_fault; rd && req_addr_i == `PSR_IDX_FAULT |=>
    rsp_rdata_o[15:13] == 3'h0 && !rsp_rdata_o[10]; endproperty
  a_fault: assert property (p_fault) else $error("fault zeros");
  property p_prog; rd && req_addr_i == `PSR_IDX_PROG_FAULT |=>
    rsp_rdata_o[15:11] == 5'h00 && rsp_rdata_o[8:0] == 9'h000; endproperty
  a_prog: assert property (p_prog) else $error("prog zeros");
  property p_temp; rd && req_addr_i == `PSR_IDX_TEMP |=> !rsp_rdata_o[15];
  endproperty
  a_temp: assert property (p_temp) else $error("temp code");
  property p_pos; rd && (req_addr_i == `PSR_IDX_POSITION ||
    req_addr_i == `PSR_IDX_OUTVAL) |=> !rsp_rdata_o[15]; endproperty
  a_pos: assert property (p_pos) else $error("position code");
  property p_maker; rd && req_addr_i == `PSR_IDX_MAKER1 |=>
    rsp_rdata_o == MAKER_INFO_1; endproperty
  a_maker: assert property (p_maker) else $error("maker word");
  // Writes below the user words never start programming.
  property p_ro; take && req_write_i && req_addr_i < `PSR_IDX_USER1 |=>
    !ack1_o; endproperty
  a_ro: assert property (p_ro) else $error("write accepted");
  property p_busy; ack1_o |-> busy_o ##1 busy_o; endproperty
  a_busy: assert property (p_busy) else $error("busy missing");
  property p_ack2; ack2_o |-> $past(busy_o) && !busy_o; endproperty
  a_ack2: assert property (p_ack2) else $error("busy after ack2");
  property p_lock; locked_o && take |=> rsp_valid_o && !ack1_o; endproperty
  a_lock: assert property (p_lock) else $error("locked access");
  // Main scenarios.
  c_ack2: cover property (ack2_o);
  c_lockrd: cover property (locked_o && rd);
  c_ro: cover property (take && req_write_i ##1 !ack1_o);
endmodule // psr_chk
bind psr_readout psr_chk #(.MAKER_INFO_1(MAKER_INFO_1),
  .PROG_CYCLES(PROG_CYCLES)) u_chk (.*);

/* File: bench/psr_prog.sv */
`timescale 1ns/1ns
`include "psr_consts.vh"
module psr_prog #(
  parameter int WAIT = 16
) (
  // Clock.
  input wire logic clk_i,
  // Requests to the sensor.
  output logic req_o = 1'b0,
  output logic req_write_o = 1'b0,
  output logic [3:0] req_addr_o = 4'h0,
  output logic [15:0] req_wdata_o = 16'h0000,
  // Answers from the sensor.
  input wire logic rsp_valid_i,
  input wire logic [15:0] rsp_rdata_i,
  input wire logic ack1_i,
  input wire logic ack2_i,
  input wire logic busy_i
);
  // One request pulse; released fields show inverted values afterwards.
  task automatic xfer(input logic w, input logic [3:0] a,
    input logic [15:0] d, output logic v, output logic [15:0] q,
    output logic k);
    @(posedge clk_i);
    req_o <= 1'b1;
    req_write_o <= w;
    req_addr_o <= a;
    req_wdata_o <= d;
    @(posedge clk_i);
    req_o <= 1'b0;
    req_addr_o <= ~a;
    req_wdata_o <= ~d;
    @(posedge clk_i);
    v = rsp_valid_i;
    q = rsp_rdata_i;
    k = ack1_i;
  endtask
  // Reads one word.
  task automatic rd(input logic [3:0] a, output logic [15:0] q,
    output logic v);
    logic k;
    xfer(1'b0, a, 16'hffff, v, q, k);
  endtask
  // Writes one word and waits for both acknowledges.
  task automatic wr(input logic [3:0] a, input logic [15:0] d,
    output logic k1, output logic k2, output logic [15:0] pf);
    logic v;
    logic [15:0] q;
    k2 = 1'b0;
    pf = 16'h0000;
    xfer(1'b1, a, d, v, q, k1);
    for (int i = 0; i < WAIT && !k2; i++) begin
      @(posedge clk_i);
      k2 = (ack2_i === 1'b1);
    end
    for (int i = 0; i < WAIT && busy_i !== 1'b0; i++) begin
      @(posedge clk_i);
    end
    if (k1 && !k2) rd(`PSR_IDX_PROG_FAULT, pf, v);
  endtask
endmodule // psr_prog

/* File: bench/tb_top.sv */
`timescale 1ns/1ns
`include "psr_consts.vh"
module tb_top;
  localparam [15:0] MK1 = 16'h1234; // Arbitrary value.
  localparam [15:0] MK2 = 16'h5678; // Arbitrary value.
  logic clk_i = 1'b0, rst_i = 1'b1, sample_i = 1'b0, rom_valid_i = 1'b0;
  logic vreg_low_i = 1'b0, adc_stuck_i = 1'b0, ch1_clip_i = 1'b0;
  logic ch2_clip_i = 1'b0, dsp_fail_i = 1'b0, nvm_fail_i = 1'b0;
  logic temp_valid_i = 1'b1, pump_low_i = 1'b0, prog_supply_low_i = 1'b0;
  logic [15:0] temp_raw_i = 16'h0000, channel1_compensated_field_i = 16'h0000;
  logic [15:0] channel2_compensated_field_i = 16'h0000, ch1_gain_corr_i = 16'h0000;
  logic [15:0] ch2_gain_corr_i = 16'h0000, position_raw_i = 16'h0000;
  logic [15:0] outval_raw_i = 16'h0000, cust_offset_i = 16'h0000;
  logic [15:0] offset_select_channel1_i = 16'h0000;
  logic [15:0] offset_select_channel2_i = 16'h0000;
  logic [15:0] clamp_hi_i = 16'h0000, clamp_lo_i = 16'h0000;
  logic [15:0] mag_hi_i = 16'h0000, mag_lo_i = 16'h0000;
  logic [16:0] rom_word_i = 17'h00000;
  wire req_i, req_write_i, rsp_valid_o, ack1_o, ack2_o, busy_o, locked_o;
  wire [3:0] req_addr_i;
  wire [15:0] req_wdata_i, rsp_rdata_o;
  logic k1, k2;
  logic [15:0] pf;
  int error_cnt = 0;
  int checked = 0;
  // Clock of 40 ns.
  always #20 clk_i = ~clk_i;
  // Sensor and programmer.
  psr_readout #(.MAKER_INFO_1(MK1), .MAKER_INFO_2(MK2), .PROG_CYCLES(4))
    DUT (.*);
  psr_prog #(.WAIT(16)) P (.clk_i(clk_i), .req_o(req_i),
    .req_write_o(req_write_i), .req_addr_o(req_addr_i),
    .req_wdata_o(req_wdata_i), .rsp_valid_i(rsp_valid_o),
    .rsp_rdata_i(rsp_rdata_o), .ack1_i(ack1_o), .ack2_i(ack2_o),
    .busy_i(busy_o));
  task automatic chk(input string n, input logic [15:0] e, g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rdchk(input string n, input logic [3:0] a,
    input logic [15:0] e);
    logic v;
    logic [15:0] q;
    P.rd(a, q, v);
    chk({n, " valid"}, 16'h0001, {15'h0000, v});
    chk(n, e, q);
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Captures processor values and lets the amplitude settle.
  task automatic samp;
    @(posedge clk_i);
    sample_i <= 1'b1;
    @(posedge clk_i);
    sample_i <= 1'b0;
    rom_valid_i <= 1'b0;
    repeat (24) @(posedge clk_i);
  endtask
  task automatic t_meas;
    @(posedge clk_i);
    temp_raw_i <= 16'h8123;
    channel1_compensated_field_i <= 16'h8000;
    channel2_compensated_field_i <= 16'h7fff;
    ch1_gain_corr_i <= 16'h0bb8;
    ch2_gain_corr_i <= 16'h0fa0;
    position_raw_i <= 16'h1234;
    outval_raw_i <= 16'hffff;
    cust_offset_i <= 16'h0064;
    samp;
    rdchk("temp", `PSR_IDX_TEMP, 16'h7fff);
    rdchk("channel1_compensated_field", `PSR_IDX_CHANNEL1_COMPENSATED_FIELD, 16'h8000);
    rdchk("channel2_compensated_field", `PSR_IDX_CHANNEL2_COMPENSATED_FIELD, 16'h7fff);
    rdchk("ch1 corr", `PSR_IDX_CH1_CORR, 16'h0bb8);
    rdchk("position", `PSR_IDX_POSITION, 16'h1234);
    rdchk("outval", `PSR_IDX_OUTVAL, 16'h7fff);
    rdchk("amp scaled", `PSR_IDX_AMPLITUDE, 16'h1f47);
    temp_raw_i <= 16'h2ee0;
    offset_select_channel1_i <= 16'h4000;
    samp;
    rdchk("temp hot", `PSR_IDX_TEMP, 16'h2ee0);
    rdchk("ch1 offset", `PSR_IDX_CH1_CORR, 16'h0c1c);
    rdchk("ch2 plain", `PSR_IDX_CH2_CORR, 16'h0fa0);
    rdchk("amp plain", `PSR_IDX_AMPLITUDE, 16'h13c4);
  endtask
  task automatic t_fault;
    @(posedge clk_i);
    {vreg_low_i, adc_stuck_i, ch1_clip_i, ch2_clip_i} <= 4'hf;
    {dsp_fail_i, nvm_fail_i, temp_valid_i} <= 3'h6;
    outval_raw_i <= 16'h4000;
    clamp_hi_i <= 16'h3000;
    clamp_lo_i <= 16'h1000;
    mag_hi_i <= 16'h03e8;
    rom_word_i <= 17'h00001;
    rom_valid_i <= 1'b1;
    samp;
    rdchk("faults", `PSR_IDX_FAULT, 16'h1afe);
    {vreg_low_i, adc_stuck_i, ch1_clip_i, ch2_clip_i} <= 4'h0;
    {dsp_fail_i, nvm_fail_i, temp_valid_i} <= 3'h1;
    clamp_hi_i <= 16'h7fff;
    clamp_lo_i <= 16'h4000;
    {mag_hi_i, mag_lo_i} <= 32'h7fff7fff;
    rom_word_i <= 17'h00003;
    rom_valid_i <= 1'b1;
    samp;
    rdchk("faults low", `PSR_IDX_FAULT, 16'h0101);
  endtask
  task automatic t_ro;
    P.wr(`PSR_IDX_TEMP, 16'h5555, k1, k2, pf);
    chk("ro ack1", 16'h0000, {15'h0000, k1});
    rdchk("temp kept", `PSR_IDX_TEMP, 16'h2ee0);
    P.wr(`PSR_IDX_MAKER1, 16'h5555, k1, k2, pf);
    chk("maker ack1", 16'h0000, {15'h0000, k1});
    rdchk("maker1", `PSR_IDX_MAKER1, MK1);
    rdchk("unmapped", 4'hf, 16'h0000);
    rdchk("user1 reset", `PSR_IDX_USER1, 16'h0000);
  endtask
  task automatic t_user;
    P.wr(`PSR_IDX_USER1, 16'hbeef, k1, k2, pf);
    chk("user ack1", 16'h0001, {15'h0000, k1});
    chk("user ack2", 16'h0001, {15'h0000, k2});
    rdchk("user1", `PSR_IDX_USER1, 16'hbeef);
    rdchk("prog ok", `PSR_IDX_PROG_FAULT, 16'h0000);
    pump_low_i <= 1'b1;
    P.wr(`PSR_IDX_USER2, 16'hcafe, k1, k2, pf);
    pump_low_i <= 1'b0;
    chk("pump ack2", 16'h0000, {15'h0000, k2});
    chk("pump flag", 16'h0400, pf);
    rdchk("user2 kept", `PSR_IDX_USER2, 16'h0000);
    prog_supply_low_i <= 1'b1;
    P.wr(`PSR_IDX_USER1, 16'h1111, k1, k2, pf);
    prog_supply_low_i <= 1'b0;
    chk("supply flag", 16'h0200, pf);
    rdchk("user1 kept", `PSR_IDX_USER1, 16'hbeef);
    P.wr(`PSR_IDX_USER2, 16'h0abc, k1, k2, pf);
    chk("user2 ack2", 16'h0001, {15'h0000, k2});
    rdchk("user2", `PSR_IDX_USER2, 16'h0abc);
  endtask
  task automatic t_lock;
    chk("lock reset", 16'h0000, {15'h0000, locked_o});
    P.wr(`PSR_IDX_LOCK, 16'h0000, k1, k2, pf);
    chk("lock zero ack1", 16'h0000, {15'h0000, k1});
    chk("lock zero", 16'h0000, {15'h0000, locked_o});
    P.wr(`PSR_IDX_LOCK, 16'h0001, k1, k2, pf);
    chk("lock ack2", 16'h0001, {15'h0000, k2});
    @(posedge clk_i);
    chk("locked", 16'h0001, {15'h0000, locked_o});
    P.wr(`PSR_IDX_USER1, 16'h2222, k1, k2, pf);
    chk("locked ack1", 16'h0000, {15'h0000, k1});
    rdchk("user1 locked", `PSR_IDX_USER1, 16'hbeef);
    rdchk("maker2", `PSR_IDX_MAKER2, MK2);
  endtask
  // Main sequence after an eight-cycle reset.
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_meas;
    t_fault;
    t_ro;
    t_user;
    t_lock;
    give_verdict;
  end
  // Watchdog well beyond the expected run length.
  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    give_verdict;
  end
endmodule // tb_top
